/* File: bench/bk3_ctrl_top_tb_top.sv */
// self-checking testbench for the buck three control block
`timescale 1ns/1ns
module bk3_ctrl_top_tb_top;
  localparam int DEB = 20; // shortened debounce count
  // clock, reset and design ports
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  bk3_pkg::bk3_pstate_t pstate = bk3_pkg::PST_OFF;
  logic [5:0] stored_setpoint = 6'h0a;
  logic hs_over_limit = 1'b0, ls_over_limit = 1'b0, light_load = 1'b1;
  bk3_pkg::bk3_drive_t drive;
  logic hs_gate_block, ls_gate_block;
  int errors = 0;
  int checks = 0;
  // free-running 250 mhz clock
  always #2 clk = ~clk;
  // device under test
  bk3_ctrl_top #(.DEB_COUNT(DEB)) i_bk3_ctrl_top (
    .clk(clk), .rst_n(rst_n),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .pstate(pstate), .stored_setpoint(stored_setpoint),
    .hs_over_limit(hs_over_limit), .ls_over_limit(ls_over_limit), .light_load(light_load),
    .drive(drive), .hs_gate_block(hs_gate_block), .ls_gate_block(ls_gate_block)
  );
  // closing report, reached from the main sequence or a timeout
  task automatic print_verdict();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // one comparison with report
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask
  // timeout handling
  task automatic hang(input string what);
    errors++;
    $display("CHECK FAILED %s expected answer seen none", what);
    print_verdict();
  endtask
  // axi4-lite write; address and data offered together, each released when taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
    int n;
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge clk);
      if (!aw_ok && s_axi_awvalid && s_axi_awready) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_ok && s_axi_wvalid && s_axi_wready) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
      if (s_axi_bvalid) break;
    end
    if (n == 100) hang("write response");
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge clk);
  endtask
  // axi4-lite read; rready held until rvalid is sampled
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
    int n;
    logic ar_ok;
    ar_ok = 1'b0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge clk);
      if (!ar_ok && s_axi_arvalid && s_axi_arready) begin
        ar_ok = 1'b1;
        s_axi_arvalid <= 1'b0;
      end
      if (s_axi_rvalid) break;
    end
    if (n == 100) hang("read data");
    d = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge clk);
  endtask
  // expected mode from state and control bits
  function automatic logic [2:0] exp_mode(input logic [1:0] p, input logic [4:0] c);
    if (p == 2'h0 || !c[0]) return bk3_pkg::MODE_OFF;
    if (p == 2'h2 && !c[1]) return bk3_pkg::MODE_OFF;
    if (p == 2'h3 && !c[2]) return bk3_pkg::MODE_OFF;
    if (c[4]) return bk3_pkg::MODE_FPWM;
    if (c[3] && p != 2'h1) return bk3_pkg::MODE_LOWPWR;
    return bk3_pkg::MODE_ADAPTIVE;
  endfunction
  // power-up from off into run, then set-point readback and write refusal
  task automatic sc_setpoint(input logic [5:0] sp, input logic [3:0] code);
    logic [31:0] d;
    logic [1:0] r;
    pstate <= bk3_pkg::PST_OFF;
    stored_setpoint <= sp;
    repeat (3) @(posedge clk);
    pstate <= bk3_pkg::PST_RUN;
    repeat (3) @(posedge clk);
    axi_rd(bk3_pkg::OFF_SETPT, d, r);
    chk("setpoints", {8'h00, 2'h0, sp, 2'h0, sp, 2'h0, sp}, d);
    axi_wr(bk3_pkg::OFF_SETPT, 32'h002a152a, r);
    chk("setpt write resp", 32'(bk3_pkg::RESP_OKAY), 32'(r));
    axi_rd(bk3_pkg::OFF_SETPT, d, r);
    chk("setpt after write", {8'h00, 2'h0, sp, 2'h0, sp, 2'h0, sp}, d);
    axi_wr(bk3_pkg::OFF_CTRL, 32'h00000001, r);
    repeat (3) @(posedge clk);
    #1;
    chk("run code", 32'(code), 32'(drive.code));
  endtask
  // every state against every control combination
  task automatic sc_mode_table();
    logic [31:0] d;
    logic [1:0] r;
    logic [2:0] m;
    for (int p = 0; p < 4; p++) begin
      for (int c = 0; c < 32; c++) begin
        pstate <= bk3_pkg::bk3_pstate_t'(p);
        axi_wr(bk3_pkg::OFF_CTRL, 32'(c), r);
        repeat (3) @(posedge clk);
        m = exp_mode(2'(p), 5'(c));
        axi_rd(bk3_pkg::OFF_STATUS, d, r);
        chk("mode", 32'(m), 32'(d[6:4]));
        chk("switching", 32'(m != bk3_pkg::MODE_OFF), 32'(drive.switching));
        chk("discharge", 32'(m == bk3_pkg::MODE_OFF), 32'(drive.discharge));
        chk("force pwm", 32'(m == bk3_pkg::MODE_FPWM), 32'(drive.force_pwm));
        chk("low bias", 32'(m == bk3_pkg::MODE_LOWPWR), 32'(drive.low_bias));
      end
    end
  endtask
  // adaptive mode at heavy load runs continuous conduction
  task automatic sc_adaptive();
    logic [1:0] r;
    pstate <= bk3_pkg::PST_RUN;
    axi_wr(bk3_pkg::OFF_CTRL, 32'h00000001, r);
    light_load <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    chk("adaptive heavy load", 32'h1, 32'(drive.force_pwm));
    light_load <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk("adaptive light load", 32'h0, 32'(drive.force_pwm));
  endtask
  // current-limit sense, gate block, interrupted and full debounce, clear
  task automatic sc_limit(input int side);
    logic [31:0] d;
    logic [1:0] r;
    if (side == 0) hs_over_limit <= 1'b1;
    else ls_over_limit <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk("gate block", 32'(side == 0 ? 2'b01 : 2'b10), 32'({ls_gate_block, hs_gate_block}));
    repeat (8) @(posedge clk);
    hs_over_limit <= 1'b0;
    ls_over_limit <= 1'b0;
    repeat (2) @(posedge clk);
    if (side == 0) hs_over_limit <= 1'b1;
    else ls_over_limit <= 1'b1;
    repeat (DEB - 8) @(posedge clk);
    axi_rd(bk3_pkg::OFF_STATUS, d, r);
    chk("sense, no flag", 32'(1 << side), d & 32'hf);
    repeat (DEB) @(posedge clk);
    axi_rd(bk3_pkg::OFF_STATUS, d, r);
    chk("sense and flag", 32'(5 << side), d & 32'hf);
    hs_over_limit <= 1'b0;
    ls_over_limit <= 1'b0;
    repeat (3) @(posedge clk);
    axi_wr(bk3_pkg::OFF_STATUS, 32'(4 << side), r);
    axi_rd(bk3_pkg::OFF_STATUS, d, r);
    chk("cleared", 32'h0, d & 32'hf);
  endtask
  // main sequence
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1;
    chk("reset drive", 32'h40, 32'(drive));
    axi_rd(bk3_pkg::OFF_CTRL, d, r);
    chk("ctrl reset", 32'h0, d);
    axi_rd(8'h0c, d, r);
    chk("unmapped resp", 32'(bk3_pkg::RESP_SLVERR), 32'(r));
    chk("unmapped data", 32'h0, d);
    sc_setpoint(6'h0a, 4'ha);
    sc_setpoint(6'h13, 4'hf);
    sc_mode_table();
    sc_adaptive();
    sc_limit(0);
    sc_limit(1);
    print_verdict();
  end
endmodule

/* File: design/bk3_ctrl_top.sv */
// top: buck three mode, set-point and current-limit control with axi4-lite registers
// Functional notes
// - set points 1.8 to 3.3 V, 100 mV
// - no dynamic voltage scaling ramps
// - auto dcm/ccm outside forced modes
// - mode forced by registers or state
// - off: stop switching, enable discharge
// - adaptive mode is the default
// - forced pwm: continuous pwm, no skipping
// - low power only in standby or sleep
// - enable 0 disables in every state
// - standby/sleep enables gate those states
// - forced pwm overrides low power
// - both bits 0 gives adaptive dcm
// - run ignores low-power bit
// - standby/sleep with low power bit: low power
// - cycle-by-cycle switch turn-off at limit
// - limit hit sets sense bit immediately
// - status set after persistent debounce interval
// - start-up copies stored set point thrice
// - state selects run/standby/sleep set point
// - set-point fields read-only, writes ignored
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ns
module bk3_ctrl_top #(
  parameter int DEB_COUNT = bk3_pkg::DEB_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // axi4-lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // device operating state and stored set point
  input wire bk3_pkg::bk3_pstate_t pstate,
  input wire logic [5:0] stored_setpoint,
  // power stage feedback
  input wire logic hs_over_limit,
  input wire logic ls_over_limit,
  input wire logic light_load,
  // power stage drive
  output bk3_pkg::bk3_drive_t drive,
  output logic hs_gate_block,
  output logic ls_gate_block
);
  // whole module state
  typedef struct packed {
    logic aw_got;
    logic [7:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    bk3_pkg::bk3_ctrl_t ctrl;
    bk3_pkg::bk3_setpt_t sp;
    bk3_pkg::bk3_pstate_t pst_prev;
    bk3_pkg::bk3_drive_t drive;
    logic hs_blk;
    logic ls_blk;
    logic [1:0] clr;
  } bk3_state_t;

  bk3_state_t st_reg; // registered state
  bk3_state_t st_next; // next state
  bk3_pkg::bk3_mode_t mode; // decoded mode
  logic hs_sense; // high-side present fault
  logic ls_sense; // low-side present fault
  logic hs_flag; // high-side debounced status
  logic ls_flag; // low-side debounced status

  // map a code to the 4-bit drive code, saturating
  function automatic logic [3:0] sp_code(input logic [5:0] v);
    sp_code = (v > {2'b00, bk3_pkg::SP_CODE_MAX}) ? bk3_pkg::SP_CODE_MAX : v[3:0];
  endfunction

  // mode decode
  bk3_mode_decode u_dec (
    .ctrl(st_reg.ctrl),
    .pstate(pstate),
    .mode(mode)
  );

  // high-side debounce
  bk3_debounce #(.DEB_COUNT(DEB_COUNT)) u_hs (
    .clk(clk),
    .rst_n(rst_n),
    .fault(hs_over_limit),
    .clr(st_reg.clr[0]),
    .sense(hs_sense),
    .flag(hs_flag)
  );

  // low-side debounce
  bk3_debounce #(.DEB_COUNT(DEB_COUNT)) u_ls (
    .clk(clk),
    .rst_n(rst_n),
    .fault(ls_over_limit),
    .clr(st_reg.clr[1]),
    .sense(ls_sense),
    .flag(ls_flag)
  );

  // bus, registers and drive next state
  always_comb begin
    st_next = st_reg;
    st_next.clr = 2'b00;
    // write address and data taken in either order
    if (s_axi_awvalid && s_axi_awready) begin
      st_next.aw_got = 1'b1;
      st_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      st_next.w_got = 1'b1;
      st_next.w_data = s_axi_wdata;
      st_next.w_strb = s_axi_wstrb;
    end
    // perform write once both halves are held
    if (st_reg.aw_got && st_reg.w_got && !st_reg.bvalid) begin
      st_next.aw_got = 1'b0;
      st_next.w_got = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp = bk3_pkg::RESP_OKAY;
      case (st_reg.aw_addr)
        bk3_pkg::OFF_CTRL: begin
          // register programming forces the mode
          if (st_reg.w_strb[0]) begin
            st_next.ctrl = st_reg.w_data[bk3_pkg::CTRL_WIDTH-1:0];
          end
        end
        bk3_pkg::OFF_SETPT: begin
          // set points are read-only, write is dropped
          st_next.bresp = bk3_pkg::RESP_OKAY;
        end
        bk3_pkg::OFF_STATUS: begin
          // write one to clear debounced flags
          if (st_reg.w_strb[0]) begin
            st_next.clr = {st_reg.w_data[bk3_pkg::ST_LS_FLAG], st_reg.w_data[bk3_pkg::ST_HS_FLAG]};
          end
        end
        default: begin
          st_next.bresp = bk3_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (st_reg.bvalid && s_axi_bready) begin
      st_next.bvalid = 1'b0;
    end
    // read
    if (s_axi_arvalid && s_axi_arready) begin
      st_next.rvalid = 1'b1;
      st_next.rresp = bk3_pkg::RESP_OKAY;
      st_next.rdata = 32'h0;
      case (s_axi_araddr)
        bk3_pkg::OFF_CTRL: begin
          st_next.rdata[bk3_pkg::CTRL_WIDTH-1:0] = st_reg.ctrl;
        end
        bk3_pkg::OFF_SETPT: begin
          st_next.rdata[bk3_pkg::SP_RUN_LSB +: bk3_pkg::SP_WIDTH] = st_reg.sp.run;
          st_next.rdata[bk3_pkg::SP_STBY_LSB +: bk3_pkg::SP_WIDTH] = st_reg.sp.stby;
          st_next.rdata[bk3_pkg::SP_SLEEP_LSB +: bk3_pkg::SP_WIDTH] = st_reg.sp.sleep;
        end
        bk3_pkg::OFF_STATUS: begin
          st_next.rdata[bk3_pkg::ST_HS_SENSE] = hs_sense;
          st_next.rdata[bk3_pkg::ST_LS_SENSE] = ls_sense;
          st_next.rdata[bk3_pkg::ST_HS_FLAG] = hs_flag;
          st_next.rdata[bk3_pkg::ST_LS_FLAG] = ls_flag;
          st_next.rdata[bk3_pkg::ST_MODE_LSB +: 3] = mode;
        end
        default: begin
          st_next.rresp = bk3_pkg::RESP_SLVERR;
        end
      endcase
    end else if (st_reg.rvalid && s_axi_rready) begin
      st_next.rvalid = 1'b0;
    end
    // start-up from off into run loads stored set point
    st_next.pst_prev = pstate;
    if (st_reg.pst_prev == bk3_pkg::PST_OFF && pstate == bk3_pkg::PST_RUN) begin
      st_next.sp.run = stored_setpoint;
      st_next.sp.stby = stored_setpoint;
      st_next.sp.sleep = stored_setpoint;
    end
    // set point chosen by state only, no ramp logic
    case (pstate)
      bk3_pkg::PST_STANDBY: st_next.drive.code = sp_code(st_reg.sp.stby);
      bk3_pkg::PST_SLEEP: st_next.drive.code = sp_code(st_reg.sp.sleep);
      default: st_next.drive.code = sp_code(st_reg.sp.run);
    endcase
    // mode to drive bits
    st_next.drive.switching = (mode != bk3_pkg::MODE_OFF);
    st_next.drive.discharge = (mode == bk3_pkg::MODE_OFF);
    st_next.drive.force_pwm = (mode == bk3_pkg::MODE_FPWM) ||
                              (mode == bk3_pkg::MODE_ADAPTIVE && !light_load);
    st_next.drive.low_bias = (mode == bk3_pkg::MODE_LOWPWR);
    // per-cycle switch turn-off at limit
    st_next.hs_blk = hs_over_limit;
    st_next.ls_blk = ls_over_limit;
  end

  // state register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_reg <= '0;
      st_reg.ctrl <= bk3_pkg::CTRL_RESET;
      st_reg.sp <= {3{bk3_pkg::SP_RESET}};
      st_reg.drive.discharge <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs
  assign s_axi_awready = !st_reg.aw_got;
  assign s_axi_wready = !st_reg.w_got;
  assign s_axi_bvalid = st_reg.bvalid;
  assign s_axi_bresp = st_reg.bresp;
  assign s_axi_arready = !st_reg.rvalid;
  assign s_axi_rvalid = st_reg.rvalid;
  assign s_axi_rdata = st_reg.rdata;
  assign s_axi_rresp = st_reg.rresp;
  assign drive = st_reg.drive;
  assign hs_gate_block = st_reg.hs_blk;
  assign ls_gate_block = st_reg.ls_blk;

  a_off_when_disabled: assert property (@(posedge clk) disable iff (!rst_n)
    !st_reg.ctrl.en |=> !drive.switching && drive.discharge) else $error("enabled with enable bit 0");
  a_standby_gate: assert property (@(posedge clk) disable iff (!rst_n)
    pstate == bk3_pkg::PST_STANDBY && !st_reg.ctrl.stby_en |=> !drive.switching) else $error("standby gate");
  a_fpwm_override: assert property (@(posedge clk) disable iff (!rst_n)
    mode != bk3_pkg::MODE_OFF && st_reg.ctrl.fpwm |=> drive.force_pwm && !drive.low_bias)
    else $error("forced pwm lost");
  a_run_no_lowpwr: assert property (@(posedge clk) disable iff (!rst_n)
    pstate == bk3_pkg::PST_RUN |=> !drive.low_bias) else $error("low power in run");
  a_lowpwr_sleep: assert property (@(posedge clk) disable iff (!rst_n)
    pstate == bk3_pkg::PST_SLEEP && st_reg.ctrl == 5'h0d |=> drive.low_bias) else $error("no low power in sleep");
  a_startup_load: assert property (@(posedge clk) disable iff (!rst_n)
    st_reg.pst_prev == bk3_pkg::PST_OFF && pstate == bk3_pkg::PST_RUN |=>
    st_reg.sp.stby == $past(stored_setpoint)) else $error("set point not loaded");
  a_setpt_readonly: assert property (@(posedge clk) disable iff (!rst_n)
    !(st_reg.pst_prev == bk3_pkg::PST_OFF && pstate == bk3_pkg::PST_RUN) |=> $stable(st_reg.sp))
    else $error("set point changed");
  a_limit_block: assert property (@(posedge clk) disable iff (!rst_n)
    hs_over_limit |=> hs_gate_block) else $error("high-side not blocked");
  // low-side switch is blocked the cycle after its limit hit
  a_ls_limit_block: assert property (@(posedge clk) disable iff (!rst_n)
    ls_over_limit |=> ls_gate_block) else $error("low-side not blocked");
  // sleep without its enable bit turns the regulator off
  a_sleep_gate: assert property (@(posedge clk) disable iff (!rst_n)
    pstate == bk3_pkg::PST_SLEEP && !st_reg.ctrl.sleep_en |=> !drive.switching && drive.discharge)
    else $error("sleep gate");
  // off mode stops switching and opens the discharge path
  a_off_discharge: assert property (@(posedge clk) disable iff (!rst_n)
    mode == bk3_pkg::MODE_OFF |=> !drive.switching && drive.discharge) else $error("off without discharge");
  // any active mode switches and releases the discharge path
  a_on_switching: assert property (@(posedge clk) disable iff (!rst_n)
    mode != bk3_pkg::MODE_OFF |=> drive.switching && !drive.discharge) else $error("active without switching");
  // forced pwm keeps continuous conduction whatever the load
  a_fpwm_continuous: assert property (@(posedge clk) disable iff (!rst_n)
    mode == bk3_pkg::MODE_FPWM |=> drive.force_pwm) else $error("forced pwm skipping");
  // adaptive mode follows the load detector
  a_adaptive_ccm: assert property (@(posedge clk) disable iff (!rst_n)
    mode == bk3_pkg::MODE_ADAPTIVE |=> drive.force_pwm == !$past(light_load)) else $error("adaptive conduction");
  // low-power mode is only reachable in standby or sleep
  a_lowpwr_states: assert property (@(posedge clk) disable iff (!rst_n)
    mode == bk3_pkg::MODE_LOWPWR |-> pstate == bk3_pkg::PST_STANDBY || pstate == bk3_pkg::PST_SLEEP)
    else $error("low power outside standby or sleep");
  // standby with enable, standby enable and low power gives low bias
  a_lowpwr_standby: assert property (@(posedge clk) disable iff (!rst_n)
    pstate == bk3_pkg::PST_STANDBY && st_reg.ctrl == 5'h0b |=> drive.low_bias)
    else $error("no low power in standby");
  // both mode bits clear on an active regulator gives adaptive
  a_dcm_default: assert property (@(posedge clk) disable iff (!rst_n)
    mode != bk3_pkg::MODE_OFF && !st_reg.ctrl.lpwr && !st_reg.ctrl.fpwm |-> mode == bk3_pkg::MODE_ADAPTIVE)
    else $error("adaptive not chosen");
  // run drives the run set point
  a_run_code: assert property (@(posedge clk) disable iff (!rst_n)
    pstate == bk3_pkg::PST_RUN |=> drive.code == sp_code($past(st_reg.sp.run))) else $error("run code");
  // standby drives the standby set point
  a_stby_code: assert property (@(posedge clk) disable iff (!rst_n)
    pstate == bk3_pkg::PST_STANDBY |=> drive.code == sp_code($past(st_reg.sp.stby))) else $error("standby code");
  // sleep drives the sleep set point
  a_sleep_code: assert property (@(posedge clk) disable iff (!rst_n)
    pstate == bk3_pkg::PST_SLEEP |=> drive.code == sp_code($past(st_reg.sp.sleep))) else $error("sleep code");
  // a control write lands in the control bits
  a_ctrl_write: assert property (@(posedge clk) disable iff (!rst_n)
    st_reg.aw_got && st_reg.w_got && !st_reg.bvalid && st_reg.aw_addr == bk3_pkg::OFF_CTRL && st_reg.w_strb[0]
    |=> st_reg.ctrl == $past(st_reg.w_data[bk3_pkg::CTRL_WIDTH-1:0])) else $error("control write lost");
  // the high-side debounced flag only rises while its fault is present
  a_hs_flag_fault: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(hs_flag) |-> hs_sense) else $error("flag without fault");
  // write response holds until taken
  a_bvalid_hold: assert property (@(posedge clk) disable iff (!rst_n)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("write response dropped");
  // read data hold until taken
  a_rvalid_hold: assert property (@(posedge clk) disable iff (!rst_n)
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  c_fpwm: cover property (@(posedge clk) drive.force_pwm && drive.switching);
  c_lowpwr: cover property (@(posedge clk) drive.low_bias);
  c_flag: cover property (@(posedge clk) hs_flag);
  c_startup: cover property (@(posedge clk) st_reg.pst_prev == bk3_pkg::PST_OFF && pstate == bk3_pkg::PST_RUN);
endmodule

/* File: design/bk3_debounce.sv */
// debounce of one current-limit event into a persistent status flag
`timescale 1ns/1ns
module bk3_debounce #(
  parameter int DEB_COUNT = bk3_pkg::DEB_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // raw fault and flag clear
  input wire logic fault,
  input wire logic clr,
  // results
  output logic sense,
  output logic flag
);
  // module state
  typedef struct packed {
    logic [bk3_pkg::DEB_W-1:0] cnt;
    logic sense;
    logic flag;
  } bk3_deb_state_t;

  bk3_deb_state_t st_reg; // registered state
  bk3_deb_state_t st_next; // next state

  // count while fault holds, restart on any gap
  always_comb begin
    st_next = st_reg;
    st_next.sense = fault;
    if (!fault) begin
      st_next.cnt = '0;
    end else if (st_reg.cnt < bk3_pkg::DEB_W'(DEB_COUNT - 1)) begin
      st_next.cnt = st_reg.cnt + 1'b1;
    end
    if (fault && st_reg.cnt == bk3_pkg::DEB_W'(DEB_COUNT - 1)) begin
      st_next.flag = 1'b1;
    end else if (clr) begin
      st_next.flag = 1'b0; // set wins over clear
    end
  end

  // state register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign sense = st_reg.sense;
  assign flag = st_reg.flag;

  a_deb_restart: assert property (@(posedge clk) disable iff (!rst_n)
    !fault |=> st_reg.cnt == '0) else $error("debounce count not restarted");
  a_deb_sense: assert property (@(posedge clk) disable iff (!rst_n)
    fault |=> sense) else $error("sense not following fault");
endmodule

/* File: design/bk3_mode_decode.sv */
// mode decode from control bits and operating state
`timescale 1ns/1ns
module bk3_mode_decode (
  // inputs
  input wire bk3_pkg::bk3_ctrl_t ctrl,
  input wire bk3_pkg::bk3_pstate_t pstate,
  // decoded mode
  output bk3_pkg::bk3_mode_t mode
);
  // table decode, enable first, then state gating, then forced pwm
  always_comb begin
    mode = bk3_pkg::MODE_ADAPTIVE;
    if (!ctrl.en || pstate == bk3_pkg::PST_OFF) begin
      mode = bk3_pkg::MODE_OFF;
    end else if (pstate == bk3_pkg::PST_STANDBY && !ctrl.stby_en) begin
      mode = bk3_pkg::MODE_OFF;
    end else if (pstate == bk3_pkg::PST_SLEEP && !ctrl.sleep_en) begin
      mode = bk3_pkg::MODE_OFF;
    end else if (ctrl.fpwm) begin
      mode = bk3_pkg::MODE_FPWM;
    end else if (ctrl.lpwr && pstate != bk3_pkg::PST_RUN) begin
      mode = bk3_pkg::MODE_LOWPWR;
    end
  end
endmodule

/* File: design/bk3_pkg.sv */
// package: offsets, fields, reset values, timing counts and types for the buck three control
package bk3_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_SETPT = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  // control register bit positions
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_STBY_BIT = 1;
  localparam int CTRL_SLEEP_BIT = 2;
  localparam int CTRL_LPWR_BIT = 3;
  localparam int CTRL_FPWM_BIT = 4;
  localparam int CTRL_WIDTH = 5;
  localparam logic [4:0] CTRL_RESET = 5'h00;
  // set-point field layout: run [5:0], standby [13:8], sleep [21:16]
  localparam int SP_WIDTH = 6;
  localparam int SP_RUN_LSB = 0;
  localparam int SP_STBY_LSB = 8;
  localparam int SP_SLEEP_LSB = 16;
  localparam logic [5:0] SP_RESET = 6'h00;
  localparam logic [3:0] SP_CODE_MAX = 4'hf;
  // set-point scale: code n gives base plus n steps, in millivolts
  localparam logic [11:0] SP_BASE_MV = 12'd1800;
  localparam logic [11:0] SP_STEP_MV = 12'd100;
  // status bit positions
  localparam int ST_HS_SENSE = 0;
  localparam int ST_LS_SENSE = 1;
  localparam int ST_HS_FLAG = 2;
  localparam int ST_LS_FLAG = 3;
  localparam int ST_MODE_LSB = 4;
  // debounce time and derived cycle count at 250 MHz
  localparam int CLK_MHZ = 250;
  localparam int DEB_TIME_US = 8000;
  localparam int DEB_CYCLES = DEB_TIME_US * CLK_MHZ;
  localparam int DEB_W = 21;
  // axi response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // device operating state input
  typedef enum logic [1:0] {PST_OFF, PST_RUN, PST_STANDBY, PST_SLEEP} bk3_pstate_t;
  // regulator operating mode
  typedef enum logic [2:0] {MODE_OFF, MODE_ADAPTIVE, MODE_FPWM, MODE_LOWPWR} bk3_mode_t;
  // control bits as a group
  typedef struct packed {
    logic fpwm;
    logic lpwr;
    logic sleep_en;
    logic stby_en;
    logic en;
  } bk3_ctrl_t;
  // set points as a group
  typedef struct packed {
    logic [5:0] sleep;
    logic [5:0] stby;
    logic [5:0] run;
  } bk3_setpt_t;
  // drive outputs to the analog power stage
  typedef struct packed {
    logic switching;
    logic discharge;
    logic force_pwm;
    logic low_bias;
    logic [3:0] code;
  } bk3_drive_t;
endpackage
